// file: psfg_ctrl_model.sv
`timescale 1ns/1ps
module psfg_ctrl_model (
  input  wire logic       clk,
  input  wire logic       rst,
  output logic      [1:0] pwm_level,
  output logic            cycle_tick
);
  logic [3:0] cnt_r;
  // Fixed 16-clock period; tri-state comes from the bench only
  always_ff @(posedge clk) begin
    if (rst) cnt_r <= 4'h0;
    else cnt_r <= cnt_r + 4'h1;
  end
  assign cycle_tick = (cnt_r == 4'hF);
  assign pwm_level  = (cnt_r < 4'h6) ? 2'h1 : 2'h0;
endmodule

// file: psfg_deadtime.sv
`timescale 1ns/1ps
module psfg_deadtime
  import psfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       req_hi,
  input  wire logic       req_lo,
  input  wire logic [7:0] dead_cyc,
  output logic            gate_hi,
  output logic            gate_lo
);

  // ----------------------------------------------------------------
  // Break-before-make sequencer
  // ----------------------------------------------------------------
  logic [7:0] gap_r;
  logic       hi_r;
  logic       lo_r;
  wire        want_hi = req_hi && !req_lo;
  wire        want_lo = req_lo && !req_hi;
  wire        both_off = !hi_r && !lo_r;

  assign gate_hi = hi_r;
  assign gate_lo = lo_r;

  // Turn-off is immediate; turn-on waits out the gap after both are off
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_r  <= 1'b0;
      lo_r  <= 1'b0;
      gap_r <= 8'h00;
    end else if (ce) begin
      if (!want_hi) hi_r <= 1'b0;
      if (!want_lo) lo_r <= 1'b0;
      if (!both_off || (!want_hi && !want_lo)) begin
        gap_r <= 8'h00;
      end else if (gap_r < dead_cyc) begin
        gap_r <= gap_r + 8'h01;
      end else begin
        hi_r <= want_hi;
        lo_r <= want_lo;
      end
    end
  end

endmodule

// file: psfg_pkg.sv
package psfg_pkg;

  // ----------------------------------------------------------------
  // Register map (APB, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] PSFG_CTRL_OFS   = 12'h000;
  localparam logic [11:0] PSFG_STATUS_OFS = 12'h004;
  localparam logic [11:0] PSFG_CFG_OFS    = 12'h008;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PSFG_CTRL_OCP_EN_BIT  = 0;
  localparam int PSFG_CTRL_DT_LSB      = 8;
  localparam int PSFG_ST_OT_BIT        = 0;
  localparam int PSFG_ST_UV_BIT        = 1;
  localparam int PSFG_ST_OC_BIT        = 2;
  localparam int PSFG_ST_HSS_BIT       = 3;
  localparam int PSFG_ST_FLAG_BIT      = 4;
  localparam int PSFG_ST_HI_BIT        = 5;
  localparam int PSFG_ST_LO_BIT        = 6;
  localparam int PSFG_ST_SCNT_LSB      = 8;
  localparam int PSFG_ST_OCCNT_LSB     = 12;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [31:0] PSFG_CTRL_RST    = 32'h0000_0201;
  localparam logic [31:0] PSFG_CFG_RST     = 32'h0000_0004;
  localparam logic [7:0]  PSFG_OC_CLEAR_CYC = 8'h80;
  localparam logic [2:0]  PSFG_HSS_CYC     = 3'h4;
  localparam logic [31:0] PSFG_DT_DEF      = 32'h0000_0002;

  // ----------------------------------------------------------------
  // Pin level codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSFG_LVL_LOW,
    PSFG_LVL_HIGH,
    PSFG_LVL_MID
  } psfg_lvl_t;

endpackage

// file: psfg_top.sv
// Contract
// - Any fault drives the fault flag high
// - Flag on temperature, bootstrap, overcurrent, short
// - Above shutdown temperature, stop switching
// - Overtemperature clears only by shutdown toggle, power
// - Overcurrent flag clears after 128 clean cycles
// - Overcurrent cuts high on-time, skips pulses
// - Sample switch node every cycle for short
// - Four consecutive short cycles declare fault
// - Short fault: flag, ignore PWM, low on
// - Short fault latched until power cycle
// - Sense pin open disables high overcurrent guard
// - Mid zero-cross enable holds both gates low
// - Tri-state PWM drives both gates low
// - Emulation mode: low off when current negative
// - PWM high: high on; low: low on
// - Gates off only after full tri-state hold-off
// - Zero-cross enable acts immediately, independent of PWM
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module psfg_top
  import psfg_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        SHUTDOWN_N_INPUT,
  input  wire logic [1:0]  ZERO_CROSS_ENABLE_N,
  input  wire logic [1:0]  PWM_LEVEL,
  input  wire logic        CYCLE_TICK,
  input  wire logic        OVER_TEMP,
  input  wire logic        BOOT_LOW,
  input  wire logic        OVERCURRENT_TRIP,
  input  wire logic        INPUT_SUPPLY_SENSE_OK,
  input  wire logic        SWITCH_NODE_SHORT,
  input  wire logic        INDUCTOR_CURRENT_NEG,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             HIGH_GATE_DRIVE,
  output logic             LOW_GATE_DRIVE,
  output logic             TEMP_FAULT_FLAG_OUT
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] cfg_r;
  logic        ot_r;
  logic        oc_r;
  logic        hss_r;
  logic        flag_r;
  logic [7:0]  occnt_r;
  logic [2:0]  scnt_r;
  logic [7:0]  tri_cnt_r;
  logic        en_d_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        skip_r;
  logic        gh_w;
  logic        gl_w;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic is_lvl(input logic [1:0] v, input psfg_lvl_t l);
    is_lvl = (v == 2'(l));
  endfunction

  wire enabled     = SHUTDOWN_N_INPUT;
  wire zc_mid      = is_lvl(ZERO_CROSS_ENABLE_N, PSFG_LVL_MID);
  wire zc_low      = is_lvl(ZERO_CROSS_ENABLE_N, PSFG_LVL_LOW);
  wire pwm_hi      = is_lvl(PWM_LEVEL, PSFG_LVL_HIGH);
  wire pwm_lo      = is_lvl(PWM_LEVEL, PSFG_LVL_LOW);
  wire pwm_tri     = !pwm_hi && !pwm_lo;
  wire [7:0] hold_cyc = cfg_r[7:0];
  wire tri_off     = pwm_tri && (tri_cnt_r >= hold_cyc);
  wire ocp_active  = ctrl_r[PSFG_CTRL_OCP_EN_BIT] && INPUT_SUPPLY_SENSE_OK;
  wire oc_now      = OVERCURRENT_TRIP && ocp_active;
  wire en_rise     = enabled && !en_d_r;
  wire stop_sw     = ot_r || OVER_TEMP || BOOT_LOW;

  // Tri-state before hold-off keeps the last driven state
  wire last_hi     = HIGH_GATE_DRIVE;
  wire eff_hi      = pwm_hi || (pwm_tri && !tri_off && last_hi);
  wire eff_lo      = pwm_lo || (pwm_tri && !tri_off && !last_hi && LOW_GATE_DRIVE);

  wire req_hi = enabled && !hss_r && !stop_sw && !zc_mid && eff_hi
                && !oc_now && !skip_r;
  wire req_lo = hss_r ? 1'b1 :
                (enabled && !stop_sw && !zc_mid && eff_lo
                 && !(zc_low && INDUCTOR_CURRENT_NEG));

  wire fault_any = ot_r || OVER_TEMP || BOOT_LOW || oc_r || hss_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire acc      = PSEL && PENABLE && !pready_r;
  wire hit_ctrl = (PADDR == PSFG_CTRL_OFS);
  wire hit_st   = (PADDR == PSFG_STATUS_OFS);
  wire hit_cfg  = (PADDR == PSFG_CFG_OFS);
  wire mapped   = hit_ctrl || hit_st || hit_cfg;
  wire [31:0] status_w = {16'h0000, occnt_r[3:0], 1'b0, scnt_r, 1'b0,
                          LOW_GATE_DRIVE, HIGH_GATE_DRIVE, flag_r,
                          hss_r, oc_r, BOOT_LOW, ot_r};
  wire [31:0] rd_w = hit_ctrl ? ctrl_r : hit_cfg ? cfg_r : hit_st ? status_w : 32'h0000_0000;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_r    <= PSFG_CTRL_RST;
      cfg_r     <= PSFG_CFG_RST;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (CE) begin
      pready_r  <= acc;
      pslverr_r <= acc && !mapped;
      if (acc && !PWRITE) prdata_r <= rd_w;
      if (acc && PWRITE && hit_ctrl) ctrl_r <= PWDATA;
      if (acc && PWRITE && hit_cfg) cfg_r <= PWDATA;
    end
  end

  // ----------------------------------------------------------------
  // Protection
  // ----------------------------------------------------------------
  // Synchronous reset stands in for the logic supply power cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ot_r      <= 1'b0;
      oc_r      <= 1'b0;
      hss_r     <= 1'b0;
      occnt_r   <= 8'h00;
      scnt_r    <= 3'h0;
      skip_r    <= 1'b0;
      en_d_r    <= 1'b0;
      tri_cnt_r <= 8'h00;
      flag_r    <= 1'b0;
    end else if (CE) begin
      en_d_r <= enabled;
      flag_r <= fault_any;
      tri_cnt_r <= !pwm_tri ? 8'h00 : (tri_off ? tri_cnt_r : tri_cnt_r + 8'h01);
      if (OVER_TEMP) begin
        ot_r <= 1'b1;
      end else if (en_rise) begin
        ot_r <= 1'b0;
      end
      if (oc_now) begin
        skip_r <= 1'b1;
      end else if (CYCLE_TICK) begin
        skip_r <= 1'b0;
      end
      if (oc_now) begin
        oc_r    <= 1'b1;
        occnt_r <= 8'h00;
      end else if (CYCLE_TICK && oc_r) begin
        if (occnt_r == PSFG_OC_CLEAR_CYC - 8'h01) begin
          oc_r    <= 1'b0;
          occnt_r <= 8'h00;
        end else begin
          occnt_r <= occnt_r + 8'h01;
        end
      end
      if (CYCLE_TICK && !hss_r) begin
        if (SWITCH_NODE_SHORT) begin
          if (scnt_r == PSFG_HSS_CYC - 3'h1) begin
            hss_r <= 1'b1;
          end
          scnt_r <= scnt_r + 3'h1;
        end else begin
          scnt_r <= 3'h0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Gate sequencing
  // ----------------------------------------------------------------
  psfg_deadtime u_dt (
    .clk      (REF_CLK),
    .rst      (RST),
    .ce       (CE),
    .req_hi   (req_hi),
    .req_lo   (req_lo),
    .dead_cyc (ctrl_r[PSFG_CTRL_DT_LSB +: 8]),
    .gate_hi  (gh_w),
    .gate_lo  (gl_w)
  );

  assign HIGH_GATE_DRIVE     = gh_w;
  assign LOW_GATE_DRIVE      = gl_w;
  assign TEMP_FAULT_FLAG_OUT = flag_r;
  assign PRDATA              = prdata_r;
  assign PREADY              = pready_r;
  assign PSLVERR             = pslverr_r;

endmodule

// file: psfg_top_asserts.sv
`timescale 1ns/1ps
module psfg_top_asserts
  import psfg_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic       CE,
  input wire logic       SHUTDOWN_N_INPUT,
  input wire logic [1:0] ZERO_CROSS_ENABLE_N,
  input wire logic [1:0] PWM_LEVEL,
  input wire logic       OVER_TEMP,
  input wire logic       BOOT_LOW,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       HIGH_GATE_DRIVE,
  input wire logic       LOW_GATE_DRIVE,
  input wire logic       TEMP_FAULT_FLAG_OUT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // Gates
  // ----------------------------------------------------------------
  a_gates_excl: assert property (!(HIGH_GATE_DRIVE && LOW_GATE_DRIVE))
    else $error("both gates on");
  a_dead_gap: assert property ($rose(HIGH_GATE_DRIVE) |-> !$past(LOW_GATE_DRIVE, 3))
    else $error("dead interval too short");
  // Low gate may stay on for a short fault, so only the high gate is checked
  a_shdn_off: assert property (!SHUTDOWN_N_INPUT [*2] |-> !HIGH_GATE_DRIVE)
    else $error("high gate on while shut down");
  a_mid_off: assert property (ZERO_CROSS_ENABLE_N == PSFG_LVL_MID [*2] |-> !HIGH_GATE_DRIVE)
    else $error("high gate on with mid zero-cross level");
  a_tri_off: assert property (PWM_LEVEL[1] [*8] |-> !HIGH_GATE_DRIVE)
    else $error("high gate on after tri-state hold-off");
  a_ot_stop: assert property (OVER_TEMP [*2] |-> !HIGH_GATE_DRIVE)
    else $error("switching while over temperature");
  // Clock enable low freezes the flag, so only enabled cycles count
  a_flag_any: assert property (CE && (OVER_TEMP || BOOT_LOW) |=> TEMP_FAULT_FLAG_OUT)
    else $error("fault flag missing");
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  a_ready_resp: assert property (CE && PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no ready in access phase");
  a_ready_pulse: assert property (CE && PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error without ready");
endmodule
bind psfg_top psfg_top_asserts u_chk (.*);

// file: psfg_top_bench.sv
`timescale 1ns/1ps
module psfg_top_bench
  import psfg_pkg::*;
;
  logic REF_CLK = 0, RST = 1, CE = 1, SHUTDOWN_N_INPUT = 0, OVER_TEMP = 0, BOOT_LOW = 0;
  logic OVERCURRENT_TRIP = 0, INPUT_SUPPLY_SENSE_OK = 1, SWITCH_NODE_SHORT = 0, INDUCTOR_CURRENT_NEG = 0;
  logic PSEL = 0, PENABLE = 0, PWRITE = 0, man = 1, hs, ls, e;
  logic [1:0]  ZERO_CROSS_ENABLE_N = 2'h1, tb_pwm = 2'h0, m_pwm, PWM_LEVEL;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic        CYCLE_TICK, PREADY, PSLVERR, HIGH_GATE_DRIVE, LOW_GATE_DRIVE, TEMP_FAULT_FLAG_OUT;
  logic [6:0]  rows [8] = '{7'h14, 7'h64, 7'h46, 7'h41, 7'h48, 7'h51, 7'h56, 7'h5C};
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
  always #4 REF_CLK = ~REF_CLK;
  assign PWM_LEVEL = man ? tb_pwm : m_pwm;
  psfg_top u_psfg_top (.*);
  psfg_ctrl_model u_psfg_ctrl_model (.clk(REF_CLK), .rst(RST), .pwm_level(m_pwm), .cycle_tick(CYCLE_TICK));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task finish_test;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cy(input int n); repeat (n) @(posedge REF_CLK); endtask
  task tk(input int n); repeat (n) @(posedge REF_CLK iff CYCLE_TICK); endtask
  // Gates seen over n cycles: any high-gate pulse, low gate held throughout
  task watch(input int n);
    hs = 0;
    ls = 1;
    repeat (n) begin
      @(posedge REF_CLK);
      hs |= HIGH_GATE_DRIVE;
      ls &= LOW_GATE_DRIVE;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, d};
    @(posedge REF_CLK);
    PENABLE <= 1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    {PSEL, PENABLE} <= 2'h0;
  endtask
  // Disable cycling is the outside party's way to clear the overtemperature latch
  task shdn_pulse; cy(1); SHUTDOWN_N_INPUT <= 0; cy(3); SHUTDOWN_N_INPUT <= 1; endtask
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test;
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cy(10);
    RST <= 0;
    cy(1);
    `CHK({HIGH_GATE_DRIVE, LOW_GATE_DRIVE, TEMP_FAULT_FLAG_OUT}, 3'h0)
    apb(0, PSFG_CTRL_OFS, 32'h0);
    `CHK(q, PSFG_CTRL_RST)
    apb(0, PSFG_CFG_OFS, 32'h0);
    `CHK(q, PSFG_CFG_RST)
    apb(0, PSFG_STATUS_OFS, 32'h0);
    `CHK(q, 32'h0000_0000)
    apb(1, 12'h00C, 32'hFFFF_FFFF);
    `CHK(e, 1'b1)
    apb(0, 12'h00C, 32'h0);
    `CHK({e, q}, {1'b1, 32'h0})
    for (int k = 0; k < 8; k++) begin
      {SHUTDOWN_N_INPUT, ZERO_CROSS_ENABLE_N, tb_pwm} <= rows[k][6:2];
      cy(12);
      `CHK({HIGH_GATE_DRIVE, LOW_GATE_DRIVE}, rows[k][1:0])
    end
    {ZERO_CROSS_ENABLE_N, tb_pwm, INDUCTOR_CURRENT_NEG} <= {2'h0, 2'h0, 1'b1};
    cy(12);
    `CHK(LOW_GATE_DRIVE, 1'b0)
    ZERO_CROSS_ENABLE_N <= 2'h1;
    cy(4);
    `CHK(LOW_GATE_DRIVE, 1'b1)
    {INDUCTOR_CURRENT_NEG, man, INPUT_SUPPLY_SENSE_OK, OVERCURRENT_TRIP} <= 4'h1;
    watch(40);
    `CHK({TEMP_FAULT_FLAG_OUT, hs}, 2'b01)
    INPUT_SUPPLY_SENSE_OK <= 1;
    cy(20);
    watch(40);
    `CHK({TEMP_FAULT_FLAG_OUT, hs}, 2'b10)
    OVERCURRENT_TRIP <= 0;
    tk(120);
    `CHK(TEMP_FAULT_FLAG_OUT, 1'b1)
    tk(12);
    `CHK(TEMP_FAULT_FLAG_OUT, 1'b0)
    OVER_TEMP <= 1;
    cy(2);
    OVER_TEMP <= 0;
    watch(40);
    `CHK({TEMP_FAULT_FLAG_OUT, hs}, 2'b10)
    shdn_pulse;
    watch(40);
    `CHK({TEMP_FAULT_FLAG_OUT, hs}, 2'b01)
    CE <= 0;
    BOOT_LOW <= 1;
    cy(3);
    `CHK(TEMP_FAULT_FLAG_OUT, 1'b0)
    CE <= 1;
    cy(3);
    `CHK(TEMP_FAULT_FLAG_OUT, 1'b1)
    BOOT_LOW <= 0;
    cy(3);
    `CHK(TEMP_FAULT_FLAG_OUT, 1'b0)
    SWITCH_NODE_SHORT <= 1;
    tk(3);
    SWITCH_NODE_SHORT <= 0;
    tk(2);
    SWITCH_NODE_SHORT <= 1;
    tk(3);
    cy(3);
    `CHK(TEMP_FAULT_FLAG_OUT, 1'b0)
    tk(1);
    cy(3);
    watch(40);
    `CHK({TEMP_FAULT_FLAG_OUT, hs, ls}, 3'b101)
    SWITCH_NODE_SHORT <= 0;
    shdn_pulse;
    cy(20);
    `CHK({TEMP_FAULT_FLAG_OUT, LOW_GATE_DRIVE}, 2'b11)
    RST <= 1;
    cy(2);
    RST <= 0;
    cy(20);
    `CHK(TEMP_FAULT_FLAG_OUT, 1'b0)
    finish_test;
  end
endmodule
